// *** common/disk_ctl_pkg.sv ***
// constants shared by the disk break/error control
`default_nettype none
package disk_ctl_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_STATUS  = 8'h00;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h04;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h08;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h0C;
   localparam logic [7:0] OFS_ADDR    = 8'h10;
   localparam logic [7:0] OFS_EXT     = 8'h14;
   // status register bit positions
   localparam int ST_LATE  = 0;
   localparam int ST_PEND  = 1;
   localparam int ST_SHOK  = 2;
   localparam int ST_PWRUP = 3;
   // interrupt bits
   localparam int IRQ_W     = 2;
   localparam int IRQ_LATE  = 0;
   localparam int IRQ_FIXED = 1;
   // widths
   localparam int AW  = 12;
   localparam int EXW = 3;
   // instruction codes, octal 6614 and 6615
   localparam logic [11:0] CODE_LOAD_EXT = 12'h0D8C;
   localparam logic [11:0] CODE_READ_EXT = 12'h0D8D;
   // shift pulses per word, one extra for the held top bit
   localparam logic [3:0] SHIFTS_DATA = 4'hC;
   localparam logic [3:0] SHIFTS_ALL  = 4'hD;
   localparam logic [AW-1:0] ADDR_ONE  = 12'h001;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage
`default_nettype wire

// *** design/addr_chain.sv ***
// serial disk address adder with shift window and redundant copy
`default_nettype none
module addr_chain (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // word timing
   input  wire logic                         word_start,
   input  wire logic                         shift_pulse,
   input  wire logic                         shift_window,
   input  wire logic                         word_check,
   // results
   output logic [disk_ctl_pkg::AW-1:0]       disk_addr,
   output logic                              addr_fixed
);
   logic [disk_ctl_pkg::AW-1:0] shreg_r;
   logic [disk_ctl_pkg::AW-1:0] shadow_r;
   logic [disk_ctl_pkg::AW-1:0] addr_r;
   logic [3:0]                  cnt_r;
   logic                        carry_r;
   logic                        lsb_r;
   logic                        fire_r;
   logic                        fixed_r;
   wire                         gated;
   wire                         in_data;
   wire                         good;

   // pulses outside the window are noise and never reach the chain
   assign gated   = shift_pulse & shift_window; // R7
   assign in_data = cnt_r < disk_ctl_pkg::SHIFTS_DATA;
   assign good    = (cnt_r == disk_ctl_pkg::SHIFTS_ALL) && (shreg_r == shadow_r); // R6

   // serial increment; carry fires a cycle after the shift to avoid the race
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shreg_r  <= '0;
         shadow_r <= '0;
         addr_r   <= '0;
         cnt_r    <= '0;
         carry_r  <= 1'b0;
         lsb_r    <= 1'b0;
         fire_r   <= 1'b0;
         fixed_r  <= 1'b0;
      end else begin
         fire_r  <= 1'b0;
         fixed_r <= 1'b0;
         if (word_start) begin
            shreg_r  <= addr_r;
            shadow_r <= addr_r + disk_ctl_pkg::ADDR_ONE; // R6
            cnt_r    <= '0;
            carry_r  <= 1'b1;
         end else if (word_check) begin
            addr_r  <= good ? shreg_r : shadow_r; // R6
            fixed_r <= ~good;
         end else begin
            if (gated && in_data) begin
               shreg_r <= {shreg_r[0] ^ carry_r, shreg_r[disk_ctl_pkg::AW-1:1]};
               lsb_r   <= shreg_r[0];
               fire_r  <= 1'b1;
            end
            // extra pulse only counts: the top bit is held one more shift;
            // later pulses count on so a gained one fails the check
            if (gated && cnt_r != '1) begin
               cnt_r <= cnt_r + 4'h1; // R5
            end
            if (fire_r) begin
               carry_r <= lsb_r & carry_r; // R5
            end
         end
      end
   end

   assign disk_addr  = addr_r;
   assign addr_fixed = fixed_r;

   a_carry_late: assert property (@(posedge pclk) disable iff (!presetn) // R5
      (gated && in_data && !word_start && !word_check) |=> fire_r)
      else $error("carry not fired one cycle after shift");
   a_window_gate: assert property (@(posedge pclk) disable iff (!presetn) // R7
      (!shift_window && !word_start && !word_check) |=> $stable(cnt_r))
      else $error("shift counted outside window");
   a_fix_mismatch: assert property (@(posedge pclk) disable iff (!presetn) // R6
      (word_check && !word_start && !good) |=> (addr_r == $past(shadow_r)) && fixed_r)
      else $error("bad address not corrected");
endmodule
`default_nettype wire

// *** design/disk_break_error_control.sv ***
// status, error detection and instruction decode of the disk control
`default_nettype none
// How it works
// (R1) address compare while break still pending sets the data-late flag
// (R2) data-late flag holds through later breaks; only system clear drops it
// (R3) code 6615 fully decoded, never taken as 6614 loading the count
// (R4) extended address loads from the accumulator on a one-cycle strobe only
// (R5) top address bit held one extra shift; carry fires a cycle later
// (R6) redundant address copy compared after shifting; mismatch restores it
// (R7) shift pulses accepted only inside the timing window
// (R8) word written before its data arrived is reported via data-late flag
// (R9) after power-up shift-permitted stays set until first instruction
module disk_break_error_control (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   // processor instruction side
   input  wire logic                         io_transfer_instruction,
   input  wire logic [11:0]                  instr_code,
   input  wire logic [11:0]                  ac_in,
   output logic [11:0]                       ac_out,
   // data break side
   input  wire logic                         break_request,
   input  wire logic                         break_done,
   input  wire logic                         addr_compare,
   input  wire logic                         word_written,
   input  wire logic                         sys_clear,
   // disk timing side
   input  wire logic                         word_start,
   input  wire logic                         shift_pulse,
   input  wire logic                         shift_window,
   input  wire logic                         word_check,
   input  wire logic                         gap_detect,
   output logic                              shift_ok,
   // interrupt
   output logic                              irq
);
   // ==========================================================
   // state
   logic                             break_pending_ff;
   logic                             data_late_flag;
   logic                             instr_q_r;
   logic                             pwrup_hold_r;
   logic                             gap_r;
   logic [disk_ctl_pkg::EXW-1:0]     extended_mem_addr_reg;
   logic [disk_ctl_pkg::EXW-1:0]     extended_disk_addr_count;
   logic [11:0]                      ac_out_r;
   logic [disk_ctl_pkg::IRQ_W-1:0]   irq_st_r;
   logic [disk_ctl_pkg::IRQ_W-1:0]   irq_st_nxt;
   logic [disk_ctl_pkg::IRQ_W-1:0]   irq_en_r;
   logic [31:0]                      prdata_r;
   logic [disk_ctl_pkg::AW-1:0]      disk_addr;
   logic                             addr_fixed;
   wire                              instr_strobe;
   wire                              dec_load;
   wire                              dec_read;
   wire                              late_evt;
   wire                              late_set;
   wire                              acc;
   wire                              wr;
   wire                              rd;
   wire                              hit_st;
   wire                              hit_ist;
   wire                              hit_clr;
   wire                              hit_en;
   wire                              hit_addr;
   wire                              hit_ext;
   wire                              mapped;
   wire [31:0]                       rd_mux;
   wire [disk_ctl_pkg::IRQ_W-1:0]    evt;
   wire [disk_ctl_pkg::IRQ_W-1:0]    clr;

   // ==========================================================
   // address chain
   addr_chain u_chain (
      .pclk         (pclk),
      .presetn      (presetn),
      .word_start   (word_start),
      .shift_pulse  (shift_pulse),
      .shift_window (shift_window),
      .word_check   (word_check),
      .disk_addr    (disk_addr),
      .addr_fixed   (addr_fixed)
   );

   // ==========================================================
   // instruction decode
   // strobe is the first cycle of the instruction only, so later ac edges miss
   assign instr_strobe = io_transfer_instruction & ~instr_q_r; // R4
   // exact twelve-bit match keeps the two codes apart
   assign dec_load = instr_strobe && (instr_code == disk_ctl_pkg::CODE_LOAD_EXT); // R3
   assign dec_read = instr_strobe && (instr_code == disk_ctl_pkg::CODE_READ_EXT); // R3

   // edge memory for the strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_q_r <= 1'b0;
      end else begin
         instr_q_r <= io_transfer_instruction;
      end
   end

   // extended address register and its counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extended_mem_addr_reg    <= '0;
         extended_disk_addr_count <= '0;
         ac_out_r                 <= '0;
      end else begin
         if (dec_load) begin
            extended_mem_addr_reg    <= ac_in[disk_ctl_pkg::EXW-1:0]; // R4
            extended_disk_addr_count <= ac_in[disk_ctl_pkg::EXW-1:0]; // R3
         end else if (break_done) begin
            extended_disk_addr_count <= extended_disk_addr_count + 3'h1;
         end
         if (dec_read) begin
            ac_out_r <= {9'h000, extended_disk_addr_count};
         end
      end
   end

   // ==========================================================
   // break pending and data late
   // a word gone to the disk with its break still pending is late
   assign late_evt = (addr_compare | word_written) & break_pending_ff; // R1 R8
   assign late_set = late_evt;

   // late flag: set wins, system clear only drops it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         break_pending_ff <= 1'b0;
         data_late_flag   <= 1'b0;
      end else begin
         if (break_request) begin
            break_pending_ff <= 1'b1;
         end else if (break_done || sys_clear) begin
            break_pending_ff <= 1'b0;
         end
         if (late_set) begin
            data_late_flag <= 1'b1; // R1 R8
         end else if (sys_clear) begin
            data_late_flag <= 1'b0; // R2
         end
      end
   end

   // ==========================================================
   // shift permitted
   // hold covers power-up when the gap timer has not seen a gap yet
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwrup_hold_r <= 1'b1;
         gap_r        <= 1'b0;
      end else begin
         if (instr_strobe) begin
            pwrup_hold_r <= 1'b0; // R9
         end
         gap_r <= gap_detect;
      end
   end
   assign shift_ok = pwrup_hold_r | gap_r; // R9

   // ==========================================================
   // apb decode
   assign acc      = psel & penable;
   assign wr       = acc & pwrite;
   assign rd       = acc & ~pwrite;
   assign hit_st   = paddr == disk_ctl_pkg::OFS_STATUS;
   assign hit_ist  = paddr == disk_ctl_pkg::OFS_IRQ_ST;
   assign hit_clr  = paddr == disk_ctl_pkg::OFS_IRQ_CLR;
   assign hit_en   = paddr == disk_ctl_pkg::OFS_IRQ_EN;
   assign hit_addr = paddr == disk_ctl_pkg::OFS_ADDR;
   assign hit_ext  = paddr == disk_ctl_pkg::OFS_EXT;
   assign mapped   = hit_st | hit_ist | hit_clr | hit_en | hit_addr | hit_ext;
   assign rd_mux   =
      hit_st   ? {28'h000_0000, ~pwrup_hold_r, shift_ok, break_pending_ff,
                  data_late_flag} :
      hit_ist  ? {30'h0000_0000, irq_st_r} :
      hit_en   ? {30'h0000_0000, irq_en_r} :
      hit_addr ? {20'h0_0000, disk_addr} :
      hit_ext  ? {26'h000_0000, extended_disk_addr_count, extended_mem_addr_reg} :
      disk_ctl_pkg::ZERO32;

   // zero wait states; read data registered at the end of the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= rd_mux;
      end
   end
   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   // ==========================================================
   // interrupts
   assign evt = {addr_fixed, late_evt};
   assign clr = (wr && hit_clr) ? pwdata[disk_ctl_pkg::IRQ_W-1:0] : '0;

   // event set wins over a clear in the same cycle
   always_comb begin
      irq_st_nxt = (irq_st_r & ~clr) | evt;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_r <= '0;
         irq_en_r <= '0;
      end else begin
         irq_st_r <= irq_st_nxt;
         if (wr && hit_en) begin
            irq_en_r <= pwdata[disk_ctl_pkg::IRQ_W-1:0];
         end
      end
   end
   assign irq    = |(irq_st_r & irq_en_r);
   assign ac_out = ac_out_r;

   // ==========================================================
   // checks
   a_late_sets: assert property (@(posedge pclk) disable iff (!presetn) // R1
      (addr_compare && break_pending_ff) |=> data_late_flag)
      else $error("late flag not set on pending compare");
   a_late_holds: assert property (@(posedge pclk) disable iff (!presetn) // R2
      (data_late_flag && !sys_clear) |=> data_late_flag)
      else $error("late flag dropped without system clear");
   a_late_clear: assert property (@(posedge pclk) disable iff (!presetn) // R2
      (sys_clear && !late_set) |=> !data_late_flag)
      else $error("system clear did not drop late flag");
   a_read_code_safe: assert property (@(posedge pclk) disable iff (!presetn) // R3
      (instr_strobe && instr_code == disk_ctl_pkg::CODE_READ_EXT && !break_done)
      |=> $stable(extended_disk_addr_count))
      else $error("6615 disturbed the extended count");
   a_load_once: assert property (@(posedge pclk) disable iff (!presetn) // R4
      (io_transfer_instruction && instr_q_r) |=> $stable(extended_mem_addr_reg))
      else $error("extended address loaded after first cycle");
   a_write_late: assert property (@(posedge pclk) disable iff (!presetn) // R8
      (word_written && break_pending_ff) |=> data_late_flag && irq_st_r[0])
      else $error("late write not reported");
   a_pwrup_shift: assert property (@(posedge pclk) disable iff (!presetn) // R9
      (pwrup_hold_r && !instr_strobe) |=> (pwrup_hold_r && shift_ok))
      else $error("shift permit dropped before first instruction");
   a_hold_ends: assert property (@(posedge pclk) disable iff (!presetn) // R9
      instr_strobe |=> !pwrup_hold_r)
      else $error("power-up hold not ended by instruction");

   // late flag, break pending and the sticky bits behind them
   a_late_irq_set: assert property (@(posedge pclk) disable iff (!presetn) // R1
      late_evt |=> irq_st_r[disk_ctl_pkg::IRQ_LATE])
      else $error("late event missed the status bit");
   a_late_no_cause: assert property (@(posedge pclk) disable iff (!presetn) // R1
      (!data_late_flag && !late_set) |=> !data_late_flag)
      else $error("late flag set without a late event");
   a_irq_clear_bit: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_clr && pwdata[disk_ctl_pkg::IRQ_LATE] && !late_evt)
      |=> !irq_st_r[disk_ctl_pkg::IRQ_LATE])
      else $error("write one did not clear the late bit");
   a_pend_set: assert property (@(posedge pclk) disable iff (!presetn)
      break_request |=> break_pending_ff)
      else $error("break request not held pending");
   a_pend_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (break_done && !break_request) |=> !break_pending_ff)
      else $error("break end did not clear pending");

   // instruction decode and the extended address
   a_load_ac: assert property (@(posedge pclk) disable iff (!presetn) // R4
      dec_load |=> extended_mem_addr_reg == $past(ac_in[disk_ctl_pkg::EXW-1:0]))
      else $error("extended address not taken on first cycle");
   a_load_exact: assert property (@(posedge pclk) disable iff (!presetn) // R3
      (instr_strobe && instr_code != disk_ctl_pkg::CODE_LOAD_EXT)
      |=> $stable(extended_mem_addr_reg))
      else $error("other code loaded the extended address");
   a_read_answer: assert property (@(posedge pclk) disable iff (!presetn) // R3
      dec_read |=> ac_out_r == {9'h000, $past(extended_disk_addr_count)})
      else $error("count not returned on read code");
   a_ac_out_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !dec_read |=> $stable(ac_out_r))
      else $error("accumulator output moved without read code");
   a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      (break_done && !dec_load)
      |=> extended_disk_addr_count == $past(extended_disk_addr_count) + 3'h1)
      else $error("extended count did not step on break end");

   // address repair and register access
   a_fix_irq_set: assert property (@(posedge pclk) disable iff (!presetn) // R6
      addr_fixed |=> irq_st_r[disk_ctl_pkg::IRQ_FIXED])
      else $error("address repair missed the status bit");
   a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && hit_en) |=> irq_en_r == $past(pwdata[disk_ctl_pkg::IRQ_W-1:0]))
      else $error("enable write not stored");
   a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && hit_st)
      |=> prdata_r[disk_ctl_pkg::ST_LATE] == $past(data_late_flag)
          && prdata_r[disk_ctl_pkg::ST_PEND] == $past(break_pending_ff))
      else $error("status read data wrong");
endmodule
`default_nettype wire

// *** test/proc_bus_model.sv ***
// processor side model: instruction bus and data break channel
`default_nettype none
module proc_bus_model (
   // clock
   input  wire logic        pclk,
   // instruction bus
   output logic             io_transfer_instruction,
   output logic [11:0]      instr_code,
   output logic [11:0]      ac_in,
   // break channel
   output logic             break_request,
   output logic             break_done,
   output logic             addr_compare,
   output logic             word_written,
   output logic             sys_clear
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================
   // idle levels at time zero
   initial begin
      io_transfer_instruction = 1'b0;
      instr_code = 12'h0000;
      ac_in = 12'h0000;
      {break_request, break_done, addr_compare, word_written, sys_clear} = 5'h00;
   end

   // ==========================================
   // instruction: two cycles high, accumulator moves at the start of the second
   task automatic instr(input logic [11:0] code, input logic [11:0] ac, input logic [11:0] ac2);
      @(posedge pclk);
      io_transfer_instruction <= 1'b1;
      instr_code <= code;
      ac_in <= ac;
      @(posedge pclk);
      ac_in <= ac2;
      @(posedge pclk);
      io_transfer_instruction <= 1'b0;
      // released lines show garbage, not the last value
      instr_code <= ~code;
      ac_in <= ~ac2;
      @(posedge pclk);
   endtask

   // ==========================================
   // one-cycle pulse on {request, done, compare, written, clear}
   task automatic pulse(input logic [4:0] m);
      @(posedge pclk);
      {break_request, break_done, addr_compare, word_written, sys_clear} <= m;
      @(posedge pclk);
      {break_request, break_done, addr_compare, word_written, sys_clear} <= 5'h00;
      @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// *** test/tb_disk_break_error_control.sv ***
// self-checking testbench of the disk break/error control
`default_nettype none
module tb_disk_break_error_control;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [4:0] P_REQ = 5'h10;
   localparam logic [4:0] P_DONE = 5'h08;
   localparam logic [4:0] P_CMP = 5'h04;
   localparam logic [4:0] P_WRT = 5'h02;
   localparam logic [4:0] P_CLR = 5'h01;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic        io_transfer_instruction, break_request, break_done, addr_compare;
   logic        word_written, sys_clear, word_start, shift_pulse, shift_window;
   logic        word_check, gap_detect, shift_ok, irq;
   logic [11:0] instr_code, ac_in, ac_out;
   int          mismatches, total_checks;

   proc_bus_model partner (.pclk(pclk), .io_transfer_instruction(io_transfer_instruction),
      .instr_code(instr_code), .ac_in(ac_in), .break_request(break_request),
      .break_done(break_done), .addr_compare(addr_compare), .word_written(word_written),
      .sys_clear(sys_clear));

   disk_break_error_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .io_transfer_instruction(io_transfer_instruction),
      .instr_code(instr_code), .ac_in(ac_in), .ac_out(ac_out), .break_request(break_request),
      .break_done(break_done), .addr_compare(addr_compare), .word_written(word_written),
      .sys_clear(sys_clear), .word_start(word_start), .shift_pulse(shift_pulse),
      .shift_window(shift_window), .word_check(word_check), .gap_detect(gap_detect),
      .shift_ok(shift_ok), .irq(irq));

   // ==========================================
   // clock, 4 ns period
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;

   // ==========================================
   // comparison and verdict
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================
   // apb master: hold everything until pready is seen high
   task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb_xfer(1'b0, a, disk_ctl_pkg::ZERO32);
      check(nm, rdat, exp);
   endtask

   // level sampled mid-cycle, after the task is entered, not at the call
   task automatic bit_chk(input string nm, input logic pick_irq, input logic exp);
      @(negedge pclk);
      check(nm, {31'h0000_0000, pick_irq ? irq : shift_ok}, {31'h0000_0000, exp});
   endtask

   // ==========================================
   // one serial word: windowed shifts, then shifts outside the window
   task automatic disk_word(input int n_in, input int n_out);
      @(posedge pclk) word_start <= 1'b1;
      @(posedge pclk) word_start <= 1'b0;
      for (int i = 0; i < n_in + n_out; i++) begin
         @(posedge pclk);
         shift_pulse <= 1'b1;
         shift_window <= (i < n_in);
         @(posedge pclk);
         shift_pulse <= 1'b0;
      end
      @(posedge pclk);
      word_check <= 1'b1;
      shift_window <= 1'b0;
      @(posedge pclk) word_check <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   // ==========================================
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      tally_and_finish();
   end

   // ==========================================
   // test sequence
   initial begin
      mismatches = 0;
      total_checks = 0;
      {presetn, psel, penable, pwrite, word_start, shift_pulse} = 6'h00;
      {shift_window, word_check, gap_detect} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      bit_chk("shift_ok hold", 1'b0, 1'b1);
      bit_chk("irq reset", 1'b1, 1'b0);
      check("ac_out reset", {20'h0_0000, ac_out}, 32'h0000_0000);
      rd(disk_ctl_pkg::OFS_STATUS, 32'h0000_0004, "status reset");
      rd(disk_ctl_pkg::OFS_IRQ_EN, 32'h0000_0000, "irq_en reset");
      rd(8'h18, 32'h0000_0000, "unmapped data");
      check("unmapped err", {31'h0000_0000, rerr}, 32'h0000_0001);
      $display("test reset done");
      // power-up hold ends on any instruction
      partner.instr(12'h0D81, 12'h000, 12'h000);
      rd(disk_ctl_pkg::OFS_STATUS, 32'h0000_0008, "status after instr");
      gap_detect <= 1'b1;
      @(posedge pclk);
      bit_chk("shift_ok gap", 1'b0, 1'b1);
      $display("test power-up done");
      // extended address load and readback
      partner.instr(disk_ctl_pkg::CODE_LOAD_EXT, 12'h005, 12'h002);
      rd(disk_ctl_pkg::OFS_EXT, 32'h0000_002D, "ext load");
      partner.instr(disk_ctl_pkg::CODE_READ_EXT, 12'h000, 12'h000);
      check("ac_out count", {20'h0_0000, ac_out}, 32'h0000_0005);
      partner.pulse(P_REQ);
      partner.pulse(P_DONE);
      partner.pulse(P_CMP);
      rd(disk_ctl_pkg::OFS_STATUS, 32'h0000_000C, "no late");
      partner.instr(disk_ctl_pkg::CODE_READ_EXT, 12'h007, 12'h007);
      check("ac_out counted", {20'h0_0000, ac_out}, 32'h0000_0006);
      rd(disk_ctl_pkg::OFS_EXT, 32'h0000_0035, "ext counted");
      $display("test decode done");
      // late flag, masking, sticky through breaks, clear
      partner.pulse(P_REQ);
      partner.pulse(P_CMP);
      rd(disk_ctl_pkg::OFS_STATUS, 32'h0000_000F, "late set");
      rd(disk_ctl_pkg::OFS_IRQ_ST, 32'h0000_0001, "irq_st late");
      bit_chk("irq masked", 1'b1, 1'b0);
      apb_xfer(1'b1, disk_ctl_pkg::OFS_IRQ_EN, 32'h0000_0003);
      bit_chk("irq enabled", 1'b1, 1'b1);
      partner.pulse(P_DONE);
      partner.pulse(P_REQ);
      partner.pulse(P_DONE);
      rd(disk_ctl_pkg::OFS_STATUS, 32'h0000_000D, "late sticky");
      apb_xfer(1'b1, disk_ctl_pkg::OFS_IRQ_CLR, 32'h0000_0001);
      bit_chk("irq cleared", 1'b1, 1'b0);
      rd(disk_ctl_pkg::OFS_IRQ_ST, 32'h0000_0000, "irq_st cleared");
      partner.pulse(P_CLR);
      rd(disk_ctl_pkg::OFS_STATUS, 32'h0000_000C, "late sys clear");
      partner.pulse(P_REQ);
      partner.pulse(P_WRT);
      rd(disk_ctl_pkg::OFS_STATUS, 32'h0000_000F, "late written");
      partner.pulse(P_DONE);
      partner.pulse(P_CLR);
      apb_xfer(1'b1, disk_ctl_pkg::OFS_IRQ_CLR, 32'h0000_0003);
      $display("test late flag done");
      // serial address increments, noise and lost or gained pulses
      for (int k = 1; k <= 6; k++) begin
         disk_word(13, 0);
         rd(disk_ctl_pkg::OFS_ADDR, 32'(k), "addr step");
      end
      disk_word(13, 1);
      rd(disk_ctl_pkg::OFS_ADDR, 32'h0000_0007, "addr noise");
      rd(disk_ctl_pkg::OFS_IRQ_ST, 32'h0000_0000, "no fix");
      disk_word(12, 0);
      rd(disk_ctl_pkg::OFS_ADDR, 32'h0000_0008, "addr lost");
      rd(disk_ctl_pkg::OFS_IRQ_ST, 32'h0000_0002, "fix lost");
      bit_chk("irq fix", 1'b1, 1'b1);
      apb_xfer(1'b1, disk_ctl_pkg::OFS_IRQ_CLR, 32'h0000_0002);
      disk_word(14, 0);
      rd(disk_ctl_pkg::OFS_ADDR, 32'h0000_0009, "addr gained");
      rd(disk_ctl_pkg::OFS_IRQ_ST, 32'h0000_0002, "fix gained");
      $display("test address chain done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
